// [pkg/gsoa_pkg.sv]
// Constants for the gauge sensor attribute block: attribute ids, codes, scalings.
// Assumes a service layer that turns fieldbus get and set services into one-cycle requests.
package gsoa_pkg;

	// ----------------------------------------------------------------
	// Attribute identifiers
	// ----------------------------------------------------------------
	localparam logic [7:0] ATT_VALUE_FORMAT   = 8'h03;
	localparam logic [7:0] ATT_UNIT_CODE      = 8'h04;
	localparam logic [7:0] ATT_READING_OK     = 8'h05;
	localparam logic [7:0] ATT_PRESSURE       = 8'h06;
	localparam logic [7:0] ATT_SUMMARY        = 8'h07;
	localparam logic [7:0] ATT_SPAN_LIMIT     = 8'h0a;
	localparam logic [7:0] ATT_FALLBACK_SEL   = 8'h19;
	localparam logic [7:0] ATT_FALLBACK_VAL   = 8'h1a;
	localparam logic [7:0] ATT_UPPER_LIMIT    = 8'h20;
	localparam logic [7:0] ATT_LOWER_LIMIT    = 8'h21;
	localparam logic [7:0] ATT_CAUTION_BITS   = 8'h5e;
	localparam logic [7:0] ATT_FAULT_BITS     = 8'h5f;
	localparam logic [7:0] ATT_EXTRA_STATUS   = 8'h60;
	localparam logic [7:0] ATT_FAMILY_CODE    = 8'h63;

	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  FMT_INT           = 8'hc3;
	localparam logic [7:0]  FMT_FLOAT         = 8'hca;
	localparam logic [15:0] UNIT_COUNTS       = 16'h1001;
	localparam logic [15:0] UNIT_MBAR         = 16'h1308;
	localparam logic [15:0] UNIT_TORR         = 16'h1301;
	localparam logic [15:0] UNIT_PA           = 16'h1309;
	localparam logic [15:0] FAMILY_CDG        = 16'h0005;
	localparam logic [7:0]  FALLBACK_SEL_RST  = 8'h00;
	localparam logic [15:0] FALLBACK_VAL_RST  = 16'h0000;
	localparam logic [15:0] INT_MAX           = 16'h7fff;
	localparam logic [15:0] INT_MIN           = 16'h8000;

	// Fallback behaviours outside the execute state.
	typedef enum logic [7:0] {
		GSOA_FB_ZERO = 8'h00,
		GSOA_FB_FULL = 8'h01,
		GSOA_FB_HOLD = 8'h02,
		GSOA_FB_SAFE = 8'h03
	} gsoa_fb_t;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int FAULT_ELEC_BIT     = 9;  // Bit 1 of the high byte.
	localparam int CAUTION_DEGAS_BIT  = 11; // Bit 3 of the high byte.
	localparam int EXT_INVALID_BIT    = 0;
	localparam int EXT_OVER_BIT       = 1;
	localparam int EXT_UNDER_BIT      = 2;
	localparam int SUM_FAULT_BIT      = 0;
	localparam int SUM_CAUTION_BIT    = 1;

	// ----------------------------------------------------------------
	// Counts conversion, log input carries FRAC fraction bits
	// ----------------------------------------------------------------
	localparam int  LOG_FRAC          = 4;
	localparam real COUNT_GAIN        = 2000.0;
	localparam real K_MBAR            = 12.5;
	localparam real K_TORR            = 12.624903;
	localparam real K_PA              = 10.5;
	localparam real LSB_SCALE         = COUNT_GAIN * (2.0 ** LOG_FRAC);
	localparam int  KOFS_MBAR         = int'(K_MBAR * LSB_SCALE);
	localparam int  KOFS_TORR         = int'(K_TORR * LSB_SCALE);
	localparam int  KOFS_PA           = int'(K_PA * LSB_SCALE);
	localparam real DEGAS_LIMIT_MBAR  = 7.2e-6;
	localparam int  DEGAS_LIMIT_SUM   = int'(($log10(DEGAS_LIMIT_MBAR) + K_MBAR) * LSB_SCALE);

	// Unit in which the incoming log pressure is expressed.
	localparam logic [1:0] LOG_IN_MBAR = 2'h0;
	localparam logic [1:0] LOG_IN_TORR = 2'h1;
	localparam logic [1:0] LOG_IN_PA   = 2'h2;

endpackage

// [src/gsoa_core.sv]
// Attribute block of the capacitance diaphragm sensor instance of a vacuum gauge.
// Assumes single-cycle get/set requests from the service layer on clk_sys and a
// log pressure feed from converter logic on the same clock.
// The electronics failure pin is the only input from outside the clock domain.
// Attribute ids on the request port are the attribute numbers themselves.
// All registers reset synchronously while rstn is low.
// Behaviour
// - Counts equal (log10 pressure plus unit constant) times 2000, as 16-bit integer.
// - Unit constant is 12.5 for mbar, 12.624903 for Torr, 10.5 for Pa.
// - Fault word is 16 bits; low byte to fault detail 4, high to 5.
// - Only fault bit 1 of high byte, electronics failure, is used; rest zero.
// - Warning word is 16 bits; bytes feed warning details 5 and 6.
// - Only warning bit 3 of high byte, degas pressure too high, is used.
// - Degas request while pressure above 7.2e-6 mbar sets the degas warning.
// - Pressure below 7.2e-6 mbar clears the degas warning.
// - Extension byte: bit0 invalid, bit1 overrange, bit2 underrange, others zero.
// - Invalid bit always equals the inverse of the validity flag.
// - Validity flag reads 1 for a valid reading, 0 otherwise.
// - Read-only upper limit, default type maximum; above it reading is invalid.
// - Read-only lower limit, default type minimum; below it reading is invalid.
// - Writable fallback select, default 0, steers value outside execute state.
// - Writable fallback value, default 0, reported when fallback select picks it.
// - Read-only family code returns 5.
// - Read-only summary byte reports combined fault and warning state.
// - Format select accepts C3 for integer, the default, and CA for float.
// - Unit codes: counts 1001, mbar 1308, Torr 1301, Pa 1309; the unit attribute always reads counts.
`timescale 1ns/1ps
`default_nettype none

module gsoa_core #(
	parameter logic [15:0] SPAN_LIMIT  = gsoa_pkg::INT_MAX,
	parameter logic [15:0] UPPER_LIMIT = gsoa_pkg::INT_MAX,
	parameter logic [15:0] LOWER_LIMIT = gsoa_pkg::INT_MIN,
	parameter int          LOG_W       = 24
) (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic              att_req,
	input  wire logic              att_write,
	input  wire logic [7:0]        att_id,
	input  wire logic [15:0]       att_wdata,
	output logic                   att_ack,
	output logic                   att_err,
	output logic [15:0]            att_rdata,
	input  wire logic              sample_stb,
	input  wire logic [LOG_W-1:0]  sample_log,
	input  wire logic [1:0]        sample_unit,
	input  wire logic              sensor_ready,
	input  wire logic              exec_state,
	input  wire logic              degas_req,
	input  wire logic              elec_fail_pin,
	output logic [7:0]             fault_detail4,
	output logic [7:0]             fault_detail5,
	output logic [7:0]             warn_detail5,
	output logic [7:0]             warn_detail6
);

	// Four guard bits keep the sum of log input and unit constant from wrapping.
	// The count width then drops the fraction bits of the log input.
	localparam int SUM_W = LOG_W + 4;
	localparam int CNT_W = SUM_W - gsoa_pkg::LOG_FRAC;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------

	logic elec_meta_q;
	logic elec_sync_q;

	// Two flops before the electronics failure pin is used.
	// The pin comes from separate monitoring circuitry and may change at any
	// time, so only the second flop feeds the fault word.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			elec_meta_q <= 1'b0;
			elec_sync_q <= 1'b0;
		end else begin
			elec_meta_q <= elec_fail_pin;
			elec_sync_q <= elec_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Counts conversion
	// ----------------------------------------------------------------

	logic signed [SUM_W-1:0] k_ofs;
	logic signed [SUM_W-1:0] log_ext;
	logic signed [SUM_W-1:0] sum_w;
	logic signed [SUM_W-1:0] sum_rnd;
	logic signed [CNT_W-1:0] cnt_w;
	logic signed [CNT_W-1:0] upper_ext;
	logic signed [CNT_W-1:0] lower_ext;
	logic signed [CNT_W-1:0] imax_ext;
	logic signed [CNT_W-1:0] imin_ext;
	logic                    over_w;
	logic                    under_w;
	logic [15:0]             cnt_sat;
	logic                    degas_above;
	logic                    degas_below;

	// Unit constant scaled by 2000 and the input fraction.
	// Torr and pascal inputs differ from millibar only by this constant, so every
	// later comparison can be made in one scaled domain.
	assign k_ofs = (sample_unit == gsoa_pkg::LOG_IN_TORR) ? SUM_W'(gsoa_pkg::KOFS_TORR) :
	               (sample_unit == gsoa_pkg::LOG_IN_PA)   ? SUM_W'(gsoa_pkg::KOFS_PA) :
	                                                        SUM_W'(gsoa_pkg::KOFS_MBAR);

	// Input already carries 2000 times log10 of pressure; add the constant and round.
	// Rounding adds half an LSB before the four fraction bits are dropped.
	assign log_ext = SUM_W'(signed'(sample_log));
	assign sum_w   = log_ext + k_ofs;
	assign sum_rnd = sum_w + SUM_W'(1 <<< (gsoa_pkg::LOG_FRAC - 1));
	assign cnt_w   = CNT_W'(sum_rnd >>> gsoa_pkg::LOG_FRAC);

	// Range checks are made on the unclipped result.
	// This way a result just past either limit is still flagged even though the
	// reported counts saturate at the end of the type.
	assign upper_ext = CNT_W'(signed'(UPPER_LIMIT));
	assign lower_ext = CNT_W'(signed'(LOWER_LIMIT));
	assign imax_ext  = CNT_W'(signed'(gsoa_pkg::INT_MAX));
	assign imin_ext  = CNT_W'(signed'(gsoa_pkg::INT_MIN));
	assign over_w    = cnt_w > upper_ext;
	assign under_w   = cnt_w < lower_ext;

	// Clip to the 16-bit integer range.
	// The reported value never wraps; it sticks at the nearest end of the type.
	assign cnt_sat = (cnt_w > imax_ext) ? gsoa_pkg::INT_MAX :
	                 (cnt_w < imin_ext) ? gsoa_pkg::INT_MIN :
	                                      cnt_w[15:0];

	// Degas threshold compared in the same scaled domain, unit independent.
	// The limit is turned into a scaled sum at elaboration, so no logarithm is
	// ever taken in hardware.
	assign degas_above = sum_w > SUM_W'(gsoa_pkg::DEGAS_LIMIT_SUM);
	assign degas_below = sum_w < SUM_W'(gsoa_pkg::DEGAS_LIMIT_SUM);

	// ----------------------------------------------------------------
	// Measurement state
	// ----------------------------------------------------------------

	logic [15:0] conv_q;
	logic        over_q;
	logic        under_q;
	logic        ok_q;
	logic        have_q;
	logic [15:0] value_q;
	logic [15:0] value_d;
	logic        degas_warn_q;
	logic        degas_warn_d;
	logic        ok_d;

	// A reading is valid once warmed up and inside both limits.
	// Warm-up is judged at the strobe, so a result taken cold stays invalid.
	assign ok_d = sensor_ready & ~over_w & ~under_w;

	// Latest result with its flags, all updated in the same edge.
	// Dropping the ready level between results clears validity without waiting
	// for the next strobe, so a cooling sensor is never reported as valid.
	// The flags never lag the result, so a read cannot see a stale pairing.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			conv_q  <= 16'h0000;
			over_q  <= 1'b0;
			under_q <= 1'b0;
			ok_q    <= 1'b0;
			have_q  <= 1'b0;
		end else if (sample_stb) begin
			conv_q  <= cnt_sat;
			over_q  <= over_w;
			under_q <= under_w;
			ok_q    <= ok_d;
			have_q  <= 1'b1;
		end else if (!sensor_ready) begin
			ok_q    <= 1'b0;
		end
	end

	logic conv_q_above;
	logic conv_q_hold;

	// Degas warning: a request above the limit sets it, falling below clears it.
	// A request between strobes is judged against the last result; an invalid
	// reading still counts, since an overrange pressure is certainly too high.
	assign degas_warn_d = (degas_req & sample_stb & degas_above) ? 1'b1 :
	                      (degas_req & ~sample_stb & conv_q_above) ? 1'b1 :
	                      (sample_stb & degas_below) ? 1'b0 :
	                      degas_warn_q;

	// The last result is held so a request between samples is judged too.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			conv_q_hold <= 1'b0;
		end else if (sample_stb) begin
			conv_q_hold <= degas_above;
		end
	end
	// Before the first result there is nothing to judge, so no warning is raised.
	assign conv_q_above = conv_q_hold & have_q;

	// Warning register; only reset or a result below the limit clears it.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			degas_warn_q <= 1'b0;
		end else begin
			degas_warn_q <= degas_warn_d;
		end
	end

	// ----------------------------------------------------------------
	// Writable attributes
	// ----------------------------------------------------------------

	logic [7:0]  fmt_q;
	logic [7:0]  fb_sel_q;
	logic [15:0] fb_val_q;
	logic        is_wr;
	logic        wr_fmt;
	logic        wr_sel;
	logic        wr_val;
	logic        fmt_ok;
	logic        sel_ok;
	logic        id_known;
	logic        wr_bad;

	// Decode of set services; only three attributes take writes.
	// A refused set leaves the stored value untouched, so a bad code never
	// reaches the value mux.
	assign is_wr  = att_req & att_write;
	assign fmt_ok = (att_wdata[7:0] == gsoa_pkg::FMT_INT) ||
	                (att_wdata[7:0] == gsoa_pkg::FMT_FLOAT);
	assign sel_ok = att_wdata[7:0] <= gsoa_pkg::GSOA_FB_SAFE;
	assign wr_fmt = is_wr & (att_id == gsoa_pkg::ATT_VALUE_FORMAT) & fmt_ok;
	assign wr_sel = is_wr & (att_id == gsoa_pkg::ATT_FALLBACK_SEL) & sel_ok;
	assign wr_val = is_wr & (att_id == gsoa_pkg::ATT_FALLBACK_VAL);
	assign wr_bad = is_wr & ~wr_fmt & ~wr_sel & ~wr_val;

	// Writable attributes, each updated only by an accepted set.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fmt_q    <= gsoa_pkg::FMT_INT;
			fb_sel_q <= gsoa_pkg::FALLBACK_SEL_RST;
			fb_val_q <= gsoa_pkg::FALLBACK_VAL_RST;
		end else begin
			if (wr_fmt) fmt_q <= att_wdata[7:0];
			if (wr_sel) fb_sel_q <= att_wdata[7:0];
			if (wr_val) fb_val_q <= att_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Reported value
	// ----------------------------------------------------------------

	// Outside execute the fallback selection decides what is reported.
	// Hold keeps the value last reported, whichever selection or result produced it.
	// Unknown codes cannot be stored, but the default still reports zero.
	always_comb begin
		value_d = value_q;
		if (exec_state) begin
			value_d = conv_q;
		end else begin
			case (gsoa_pkg::gsoa_fb_t'(fb_sel_q))
				gsoa_pkg::GSOA_FB_ZERO: value_d = 16'h0000;
				gsoa_pkg::GSOA_FB_FULL: value_d = SPAN_LIMIT;
				gsoa_pkg::GSOA_FB_HOLD: value_d = value_q;
				gsoa_pkg::GSOA_FB_SAFE: value_d = fb_val_q;
				default:                value_d = 16'h0000;
			endcase
		end
	end

	// Reported value register, read by the get service.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			value_q <= 16'h0000;
		end else begin
			value_q <= value_d;
		end
	end

	// ----------------------------------------------------------------
	// Status words
	// ----------------------------------------------------------------

	logic [15:0] fault_w;
	logic [15:0] caution_w;
	logic [7:0]  ext_w;
	logic [7:0]  sum_byte;

	// Only the documented bits are ever set; all others stay zero.
	// The summary byte is derived from the words, so it can never disagree.
	always_comb begin
		fault_w   = 16'h0000;
		caution_w = 16'h0000;
		ext_w     = 8'h00;
		sum_byte  = 8'h00;
		fault_w[gsoa_pkg::FAULT_ELEC_BIT]      = elec_sync_q;
		caution_w[gsoa_pkg::CAUTION_DEGAS_BIT] = degas_warn_q;
		ext_w[gsoa_pkg::EXT_INVALID_BIT]       = ~ok_q;
		ext_w[gsoa_pkg::EXT_OVER_BIT]          = over_q;
		ext_w[gsoa_pkg::EXT_UNDER_BIT]         = under_q;
		sum_byte[gsoa_pkg::SUM_FAULT_BIT]      = |fault_w;
		sum_byte[gsoa_pkg::SUM_CAUTION_BIT]    = |caution_w;
	end

	// Exception detail bytes follow the status words.
	// They lag the words by one edge because every output comes from a flop.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fault_detail4 <= 8'h00;
			fault_detail5 <= 8'h00;
			warn_detail5  <= 8'h00;
			warn_detail6  <= 8'h00;
		end else begin
			fault_detail4 <= fault_w[7:0];
			fault_detail5 <= fault_w[15:8];
			warn_detail5  <= caution_w[7:0];
			warn_detail6  <= caution_w[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Get service read mux
	// ----------------------------------------------------------------

	logic [15:0] rd_w;

	// Unknown ids answer zero data with the error flag.
	// Eight-bit attributes are zero-extended so the master sees one width.
	always_comb begin
		rd_w     = 16'h0000;
		id_known = 1'b1;
		case (att_id)
			gsoa_pkg::ATT_VALUE_FORMAT: rd_w = {8'h00, fmt_q};
			gsoa_pkg::ATT_UNIT_CODE:    rd_w = gsoa_pkg::UNIT_COUNTS;
			gsoa_pkg::ATT_READING_OK:   rd_w = {15'h0000, ok_q};
			gsoa_pkg::ATT_PRESSURE:     rd_w = value_q;
			gsoa_pkg::ATT_SUMMARY:      rd_w = {8'h00, sum_byte};
			gsoa_pkg::ATT_SPAN_LIMIT:   rd_w = SPAN_LIMIT;
			gsoa_pkg::ATT_FALLBACK_SEL: rd_w = {8'h00, fb_sel_q};
			gsoa_pkg::ATT_FALLBACK_VAL: rd_w = fb_val_q;
			gsoa_pkg::ATT_UPPER_LIMIT:  rd_w = UPPER_LIMIT;
			gsoa_pkg::ATT_LOWER_LIMIT:  rd_w = LOWER_LIMIT;
			gsoa_pkg::ATT_CAUTION_BITS: rd_w = caution_w;
			gsoa_pkg::ATT_FAULT_BITS:   rd_w = fault_w;
			gsoa_pkg::ATT_EXTRA_STATUS: rd_w = {8'h00, ext_w};
			gsoa_pkg::ATT_FAMILY_CODE:  rd_w = gsoa_pkg::FAMILY_CDG;
			default:                    id_known = 1'b0;
		endcase
	end

	// One answer per request, on the next edge.
	// A refused request still gets its acknowledge, with zero data, so the
	// master never waits on a request that the block will not serve.
	// Back-to-back requests are answered back to back.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			att_ack   <= 1'b0;
			att_err   <= 1'b0;
			att_rdata <= 16'h0000;
		end else begin
			att_ack   <= att_req;
			att_err   <= att_req & (~id_known | wr_bad);
			att_rdata <= (att_req & ~att_write & id_known) ? rd_w : 16'h0000;
		end
	end

endmodule

`default_nettype wire

// [dv/gsoa_core_assertions.sv]
// Port checker for the gauge sensor attribute block.
// Assumes it is bound into gsoa_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module gsoa_core_assertions #(
	parameter int LOG_W = 24
) (
	input wire logic             clk_sys,
	input wire logic             rstn,
	input wire logic             att_req,
	input wire logic             att_write,
	input wire logic [7:0]       att_id,
	input wire logic             att_ack,
	input wire logic             att_err,
	input wire logic [15:0]      att_rdata,
	input wire logic             sample_stb,
	input wire logic [LOG_W-1:0] sample_log,
	input wire logic [1:0]       sample_unit,
	input wire logic             degas_req,
	input wire logic             elec_fail_pin,
	input wire logic [7:0]       fault_detail4,
	input wire logic [7:0]       fault_detail5,
	input wire logic [7:0]       warn_detail5,
	input wire logic [7:0]       warn_detail6
);
	// ----------------------------------------------------------------
	// Port relations
	// ----------------------------------------------------------------
	// Degas limit in the mbar log domain, with a small guard for rounding.
	localparam int HI_LOG = -164550;
	localparam int LO_LOG = -164582;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Writes outside the writable ids are answered with an error.
	ro_refuse_a: assert property (att_req && att_write &&
		!(att_id inside {8'h03, 8'h19, 8'h1a}) |=> att_ack && att_err)
		else $error("write to read-only id not refused");
	ack_only_a: assert property (!att_req |=> !att_ack && !att_err && att_rdata == 16'h0)
		else $error("answer without request");
	family_ro_a: assert property (att_req && !att_write && att_id == 8'h63 |=>
		att_ack && !att_err && att_rdata == 16'h0005) else $error("family code wrong");
	ext_rsvd_a: assert property (att_req && !att_write && att_id == 8'h60 |=>
		att_ack && att_rdata[15:3] == 13'h0) else $error("extension spare bits set");
	fault_low_a: assert property (fault_detail4 == 8'h00)
		else $error("fault low byte not zero");
	fault_high_a: assert property ((fault_detail5 & 8'hfd) == 8'h00)
		else $error("fault high byte spare bit set");
	warn_bits_a: assert property (warn_detail5 == 8'h00 && (warn_detail6 & 8'hf7) == 8'h00)
		else $error("warning spare bit set");
	fault_set_a: assert property (elec_fail_pin [*5] |-> fault_detail5[1])
		else $error("electronics failure not mapped");
	fault_clr_a: assert property (!elec_fail_pin [*5] |-> !fault_detail5[1])
		else $error("electronics failure stuck");
	degas_set_a: assert property (degas_req && sample_stb && sample_unit == 2'h0 &&
		$signed(sample_log) > HI_LOG |-> ##[1:2] warn_detail6[3]) else $error("degas warning not set");
	degas_clr_a: assert property (!degas_req && sample_stb && sample_unit == 2'h0 &&
		$signed(sample_log) < LO_LOG |-> ##[1:2] !warn_detail6[3]) else $error("degas warning kept");
	// Main scenarios reached.
	refuse_c: cover property (att_ack && att_err);
	degas_c: cover property ($rose(warn_detail6[3]));
	fault_c: cover property ($rose(fault_detail5[1]));
endmodule
bind gsoa_core gsoa_core_assertions #(.LOG_W(LOG_W)) i_chk (.clk_sys(clk_sys), .rstn(rstn),
	.att_req(att_req), .att_write(att_write), .att_id(att_id), .att_ack(att_ack),
	.att_err(att_err), .att_rdata(att_rdata), .sample_stb(sample_stb),
	.sample_log(sample_log), .sample_unit(sample_unit), .degas_req(degas_req),
	.elec_fail_pin(elec_fail_pin), .fault_detail4(fault_detail4),
	.fault_detail5(fault_detail5), .warn_detail5(warn_detail5), .warn_detail6(warn_detail6));
`default_nettype wire

// [dv/gsoa_master.sv]
// Service master model that issues get and set requests to the attribute port.
// Assumes the testbench calls xfer and that answers come one cycle after taking.
`timescale 1ns/1ps
`default_nettype none
module gsoa_master (
	input  wire logic        clk_sys,
	output logic             att_req,
	output logic             att_write,
	output logic [7:0]       att_id,
	output logic [15:0]      att_wdata,
	input  wire logic        att_ack,
	input  wire logic        att_err,
	input  wire logic [15:0] att_rdata
);
	// ----------------------------------------------------------------
	// Request driver
	// ----------------------------------------------------------------
	// Idle levels; released data shows its inverse so stale values never pass.
	initial begin
		att_req   = 1'b0;
		att_write = 1'b0;
		att_id    = 8'h00;
		att_wdata = 16'h0000;
	end
	// One pulse request; the answer is taken at the edge after the taking edge.
	task automatic xfer(input logic w, input logic [7:0] id, input logic [15:0] d,
		output logic [15:0] q, output logic e, output logic a);
		@(posedge clk_sys);
		att_req   <= 1'b1;
		att_write <= w;
		att_id    <= id;
		att_wdata <= d;
		@(posedge clk_sys);
		att_req   <= 1'b0;
		att_write <= 1'b0;
		att_wdata <= ~d;
		@(posedge clk_sys);
		a = att_ack;
		e = att_err;
		q = att_rdata;
	endtask
endmodule
`default_nettype wire

// [dv/gsoa_core_tb_top.sv]
// Self-checking bench for the gauge sensor attribute block.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module gsoa_core_tb_top;
	logic clk_sys, rstn, sample_stb, sensor_ready, exec_state, degas_req, elec_fail_pin;
	logic att_req, att_write, att_ack, att_err, e, a;
	logic [7:0]  att_id, fault_detail4, fault_detail5, warn_detail5, warn_detail6;
	logic [15:0] att_wdata, att_rdata, q;
	logic [23:0] sample_log;
	logic [1:0]  sample_unit, u;
	int          bad_count, n_checks, seed, l, c;
	logic [7:0]  rid [0:9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h0a, 8'h63};
	logic [15:0] rex [0:9] = '{16'h00c3, 16'h1001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h7fff,
		16'h8000, 16'h7fff, 16'h0005};
	logic [7:0]  ro [0:11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h20, 8'h21, 8'h5e,
		8'h5f, 8'h60, 8'h63, 8'h42};
	int          corner [0:2] = '{7767, 7768, -57769};
	gsoa_core i_dut (.clk_sys(clk_sys), .rstn(rstn), .att_req(att_req), .att_write(att_write),
		.att_id(att_id), .att_wdata(att_wdata), .att_ack(att_ack), .att_err(att_err),
		.att_rdata(att_rdata), .sample_stb(sample_stb), .sample_log(sample_log),
		.sample_unit(sample_unit), .sensor_ready(sensor_ready), .exec_state(exec_state),
		.degas_req(degas_req), .elec_fail_pin(elec_fail_pin), .fault_detail4(fault_detail4),
		.fault_detail5(fault_detail5), .warn_detail5(warn_detail5), .warn_detail6(warn_detail6));
	gsoa_master i_mst (.clk_sys(clk_sys), .att_req(att_req), .att_write(att_write),
		.att_id(att_id), .att_wdata(att_wdata), .att_ack(att_ack), .att_err(att_err),
		.att_rdata(att_rdata));
	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk_val(input logic [15:0] g, input logic [15:0] x);
		n_checks++;
		if (g !== x) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task chk_flag(input logic g, input logic x);
		chk_val({15'h0, g}, {15'h0, x});
	endtask
	task rd(input logic [7:0] id, input logic [15:0] x);
		i_mst.xfer(1'b0, id, 16'h0, q, e, a);
		chk_flag(a & ~e, 1'b1);
		chk_val(q, x);
	endtask
	task wr(input logic [7:0] id, input logic [15:0] d, input logic xe);
		i_mst.xfer(1'b1, id, d, q, e, a);
		chk_flag(a, 1'b1);
		chk_flag(e, xe);
	endtask
	task smp(input logic [1:0] su, input int sl, input logic dg);
		@(posedge clk_sys);
		sample_stb <= 1'b1;
		sample_unit <= su;
		sample_log <= 24'(16 * sl);
		degas_req <= dg;
		@(posedge clk_sys);
		sample_stb <= 1'b0;
		degas_req <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	// Unclipped counts for a log input that is a whole number of counts.
	function automatic int exp_cnt(input logic [1:0] su, input int sl);
		return sl + (su == 2'h1 ? 25250 : (su == 2'h2 ? 21000 : 25000));
	endfunction
	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		stop_test;
	end
	initial begin
		seed = 32'h37e1;
		{rstn, sample_stb, sensor_ready, exec_state, degas_req, elec_fail_pin} = 6'h04;
		sample_log = 24'h0;
		sample_unit = 2'h0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 10; i++) rd(rid[i], rex[i]);
		rd(8'h60, 16'h0001);
		for (int i = 0; i < 12; i++) wr(ro[i], 16'h0055, 1'b1);
		i_mst.xfer(1'b0, 8'h42, 16'h0, q, e, a);
		chk_val(q, 16'h0);
		wr(8'h03, 16'h0055, 1'b1);
		rd(8'h03, 16'h00c3);
		wr(8'h03, 16'h00ca, 1'b0);
		rd(8'h03, 16'h00ca);
		smp(2'h0, -20000, 1'b0);
		rd(8'h05, 16'h0000);
		@(posedge clk_sys) sensor_ready <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			l = i < 3 ? corner[i] : $random(seed) % 45000;
			u = i < 3 ? 2'h0 : 2'($unsigned($random(seed)) % 3);
			smp(u, l, 1'b0);
			c = exp_cnt(u, l);
			rd(8'h05, {15'h0, c <= 32767 && c >= -32768});
			rd(8'h60, {13'h0, c < -32768, c > 32767, c > 32767 || c < -32768});
			rd(8'h06, c > 32767 ? 16'h7fff : (c < -32768 ? 16'h8000 : 16'(c)));
		end
		smp(2'h0, -5000, 1'b1);
		chk_val({8'h0, warn_detail6}, 16'h0008);
		rd(8'h5e, 16'h0800);
		rd(8'h07, 16'h0002);
		smp(2'h0, -20000, 1'b0);
		rd(8'h5e, 16'h0000);
		smp(2'h0, -5000, 1'b0);
		rd(8'h5e, 16'h0000);
		@(posedge clk_sys) degas_req <= 1'b1;
		@(posedge clk_sys) degas_req <= 1'b0;
		rd(8'h5e, 16'h0800);
		smp(2'h0, -20000, 1'b0);
		rd(8'h5e, 16'h0000);
		@(posedge clk_sys) elec_fail_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk_val({fault_detail5, fault_detail4}, 16'h0200);
		rd(8'h5f, 16'h0200);
		rd(8'h07, 16'h0001);
		@(posedge clk_sys) elec_fail_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(8'h5f, 16'h0000);
		@(posedge clk_sys) exec_state <= 1'b0;
		wr(8'h19, 16'h0003, 1'b0);
		wr(8'h1a, 16'h1234, 1'b0);
		rd(8'h1a, 16'h1234);
		rd(8'h06, 16'h1234);
		wr(8'h19, 16'h0001, 1'b0);
		rd(8'h06, 16'h7fff);
		wr(8'h19, 16'h0000, 1'b0);
		rd(8'h06, 16'h0000);
		wr(8'h19, 16'h0003, 1'b0);
		wr(8'h19, 16'h0002, 1'b0);
		smp(2'h0, -20000, 1'b0);
		rd(8'h06, 16'h1234);
		@(posedge clk_sys) exec_state <= 1'b1;
		rd(8'h06, 16'h1388);
		wr(8'h19, 16'h0004, 1'b1);
		rd(8'h19, 16'h0002);
		stop_test;
	end
endmodule
`default_nettype wire
